/* File: rtl/bit_shift_flag_params.svh */
`ifndef BIT_SHIFT_FLAG_PARAMS_SVH
`define BIT_SHIFT_FLAG_PARAMS_SVH

// status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// reset values
`define FLAGS_RST 8'h00
`define BYTE_RST 8'h00

// cycle counts
`define CYC_IO_BIT 2'h2
`define CYC_SINGLE 2'h1

`endif

/* File: rtl/bit_shift_flag_pkg.sv */
package bit_shift_flag_pkg;
    // operation codes
    typedef enum logic [4:0] {
        op_nop = 5'h00,
        io_bit_set = 5'h01,
        io_bit_clear = 5'h02,
        shift_left_logical = 5'h03,
        shift_right_logical = 5'h04,
        rotate_left_carry = 5'h05,
        rotate_right_carry = 5'h06,
        shift_right_arith = 5'h07,
        nibble_swap = 5'h08,
        flag_index_set = 5'h09,
        flag_index_clear = 5'h0a,
        bit_to_transfer_flag = 5'h0b,
        transfer_flag_to_bit = 5'h0c,
        carry_set = 5'h0d,
        carry_clear = 5'h0e,
        negative_set = 5'h0f,
        negative_clear = 5'h10,
        zero_set = 5'h11,
        zero_clear = 5'h12,
        int_enable_set = 5'h13,
        int_enable_clear = 5'h14,
        signed_flag_set = 5'h15,
        signed_flag_clear = 5'h16,
        overflow_flag_set = 5'h17,
        overflow_flag_clear = 5'h18,
        transfer_set = 5'h19,
        transfer_clear = 5'h1a,
        half_carry_set = 5'h1b,
        half_carry_clear = 5'h1c
    } op_t;

    // one-hot sequencer states
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_io2 = 2'b10
    } state_t;

    // instruction request from the decoder
    typedef struct packed {
        logic valid;
        op_t op;
        logic [2:0] sel;
        logic [7:0] operand;
    } req_t;

    // result toward register file and i/o space
    typedef struct packed {
        logic reg_we;
        logic [7:0] reg_data;
        logic io_we;
        logic [7:0] io_data;
        logic done;
        logic [1:0] cycles;
    } res_t;

    typedef struct packed {
        state_t state;
        logic [7:0] flags;
        logic [7:0] io_hold;
        res_t res;
    } core_t;
endpackage : bit_shift_flag_pkg

/* File: rtl/bit_shift_flag_unit.sv */
// Functional notes
// (RULE1) io_bit_set writes 1 to the chosen bit of the i/o byte, keeps flags, takes 2 cycles.
// (RULE2) io_bit_clear writes 0 to the chosen bit of the i/o byte, keeps flags, takes 2 cycles.
// (RULE3) shift_left_logical moves bits up, feeds 0 into bit 0, updates Z C N V, 1 cycle.
// (RULE4) shift_right_logical moves bits down, feeds 0 into bit 7, updates Z C N V, 1 cycle.
// (RULE5) rotate_left_carry feeds old carry into bit 0 and bit 7 into carry, 1 cycle.
// (RULE6) rotate_right_carry feeds old carry into bit 7 and bit 0 into carry, 1 cycle.
// (RULE7) shift_right_arith shifts down keeping bit 7, updates Z C N V, 1 cycle.
// (RULE8) nibble_swap exchanges the two nibbles in 1 cycle with flags kept.
// (RULE9) bit_to_transfer_flag copies the chosen operand bit into T only, 1 cycle.
// (RULE10) transfer_flag_to_bit writes T into the chosen bit, flags kept, 1 cycle.
// (RULE11) overflow set and clear touch only V in 1 cycle.
// (RULE12) half-carry set and clear touch only H in 1 cycle.
// (RULE13) signed flag set and clear touch only S in 1 cycle.
// (RULE14) C, N, Z, T and I each have their own set and clear, touching only that flag.
// (RULE15) flag_index_set and flag_index_clear write one flag chosen by a 3-bit index in 1 cycle.
// (RULE16) shifts set Z on zero result, N from bit 7 and V as N xor C.
`timescale 1ns/1ps
`include "bit_shift_flag_params.svh"

module bit_shift_flag_unit
    import bit_shift_flag_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // decoder request
    input req_t req,
    // i/o byte read for the bit set and clear read-modify-write
    input wire logic [7:0] io_rdata,
    // results
    output res_t res,
    output logic [7:0] flags,
    output logic busy
);

    core_t r_r;
    core_t r_nxt;

    // single-bit update of a byte at a runtime index
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] i,
                                           input logic b);
        logic [7:0] o;
        o = v;
        o[i] = b;
        return o;
    endfunction : put_bit

    // shift result flags; S is left alone, only Z C N V are listed as affected
    function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] y,
                                               input logic c);
        logic [7:0] o;
        o = f;
        o[`FLAG_Z] = (y == `BYTE_RST); // RULE16
        o[`FLAG_C] = c;
        o[`FLAG_N] = y[7]; // RULE16
        o[`FLAG_V] = y[7] ^ c; // RULE16
        return o;
    endfunction : shift_flags

    always_comb begin
        logic [7:0] y;
        logic c;
        y = req.operand;
        c = 1'b0;
        r_nxt = r_r;
        r_nxt.res.reg_we = 1'b0;
        r_nxt.res.io_we = 1'b0;
        r_nxt.res.done = 1'b0;
        case (r_r.state)
            st_idle: begin
                if (req.valid) begin
                    r_nxt.res.done = 1'b1;
                    r_nxt.res.cycles = `CYC_SINGLE;
                    r_nxt.res.reg_data = r_r.res.reg_data;
                    case (req.op)
                        // i/o bit ops finish in a second cycle so the write lands on cycle 2
                        io_bit_set: begin
                            r_nxt.io_hold = put_bit(io_rdata, req.sel, 1'b1); // RULE1
                            r_nxt.res.done = 1'b0;
                            r_nxt.state = st_io2; // RULE1
                        end

                        // clear variant mirrors the set path; the hold byte carries the edit
                        io_bit_clear: begin
                            r_nxt.io_hold = put_bit(io_rdata, req.sel, 1'b0); // RULE2
                            r_nxt.res.done = 1'b0;
                            r_nxt.state = st_io2; // RULE2
                        end

                        // logical left: bit 7 leaves through carry
                        shift_left_logical: begin
                            y = {req.operand[6:0], 1'b0}; // RULE3
                            c = req.operand[7];
                            r_nxt.flags = shift_flags(r_r.flags, y, c); // RULE3
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = y;
                        end

                        // logical right: bit 0 leaves through carry, a zero enters at the top
                        shift_right_logical: begin
                            y = {1'b0, req.operand[7:1]}; // RULE4
                            c = req.operand[0];
                            r_nxt.flags = shift_flags(r_r.flags, y, c); // RULE4
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = y;
                        end

                        // rotates reuse the stored carry, so back-to-back rotates chain cleanly
                        rotate_left_carry: begin
                            y = {req.operand[6:0], r_r.flags[`FLAG_C]}; // RULE5
                            c = req.operand[7]; // RULE5
                            r_nxt.flags = shift_flags(r_r.flags, y, c);
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = y;
                        end

                        // right rotate: the stored carry re-enters at the top
                        rotate_right_carry: begin
                            y = {r_r.flags[`FLAG_C], req.operand[7:1]}; // RULE6
                            c = req.operand[0]; // RULE6
                            r_nxt.flags = shift_flags(r_r.flags, y, c);
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = y;
                        end

                        // arithmetic right: the sign bit is copied so negatives stay negative
                        shift_right_arith: begin
                            y = {req.operand[7], req.operand[7:1]}; // RULE7
                            c = req.operand[0];
                            r_nxt.flags = shift_flags(r_r.flags, y, c); // RULE7
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = y;
                        end

                        // nibble exchange: flags are not part of the result
                        nibble_swap: begin
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = {req.operand[3:0], req.operand[7:4]}; // RULE8
                        end

                        // bit store: only the transfer flag moves
                        bit_to_transfer_flag:
                            r_nxt.flags[`FLAG_T] = req.operand[req.sel]; // RULE9

                        // bit load: the operand comes back with one bit replaced by T
                        transfer_flag_to_bit: begin
                            r_nxt.res.reg_we = 1'b1;
                            r_nxt.res.reg_data = put_bit(req.operand, req.sel,
                                                         r_r.flags[`FLAG_T]); // RULE10
                        end

                        // generic flag write; the index reaches all eight status bits
                        flag_index_set: r_nxt.flags[req.sel] = 1'b1; // RULE15
                        flag_index_clear: r_nxt.flags[req.sel] = 1'b0; // RULE15

                        // dedicated overflow writes
                        overflow_flag_set: r_nxt.flags[`FLAG_V] = 1'b1; // RULE11
                        overflow_flag_clear: r_nxt.flags[`FLAG_V] = 1'b0; // RULE11

                        // dedicated half-carry writes
                        half_carry_set: r_nxt.flags[`FLAG_H] = 1'b1; // RULE12
                        half_carry_clear: r_nxt.flags[`FLAG_H] = 1'b0; // RULE12

                        // dedicated signed-test writes
                        signed_flag_set: r_nxt.flags[`FLAG_S] = 1'b1; // RULE13
                        signed_flag_clear: r_nxt.flags[`FLAG_S] = 1'b0; // RULE13

                        // dedicated carry writes
                        carry_set: r_nxt.flags[`FLAG_C] = 1'b1; // RULE14
                        carry_clear: r_nxt.flags[`FLAG_C] = 1'b0; // RULE14

                        // dedicated negative writes
                        negative_set: r_nxt.flags[`FLAG_N] = 1'b1; // RULE14
                        negative_clear: r_nxt.flags[`FLAG_N] = 1'b0; // RULE14

                        // dedicated zero writes
                        zero_set: r_nxt.flags[`FLAG_Z] = 1'b1; // RULE14
                        zero_clear: r_nxt.flags[`FLAG_Z] = 1'b0; // RULE14

                        // dedicated transfer flag writes
                        transfer_set: r_nxt.flags[`FLAG_T] = 1'b1; // RULE14
                        transfer_clear: r_nxt.flags[`FLAG_T] = 1'b0; // RULE14

                        // dedicated interrupt enable writes; no interrupt logic lives here
                        int_enable_set: r_nxt.flags[`FLAG_I] = 1'b1; // RULE14
                        int_enable_clear: r_nxt.flags[`FLAG_I] = 1'b0; // RULE14

                        // unknown codes still pulse done so the decoder never stalls
                        default: r_nxt.res.done = 1'b1; // no-op completes in one cycle
                    endcase
                end
            end
            st_io2: begin
                // flags untouched; request input is ignored while busy
                r_nxt.res.io_we = 1'b1; // RULE1 RULE2
                r_nxt.res.io_data = r_r.io_hold;
                r_nxt.res.done = 1'b1;
                r_nxt.res.cycles = `CYC_IO_BIT;
                r_nxt.state = st_idle;
            end
            default: r_nxt.state = st_idle;
        endcase
    end

    // single register stage holds every piece of state
    // data fields are cleared as well, so the first trace after reset holds no unknowns
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_r.state <= st_idle;
            r_r.flags <= `FLAGS_RST;
            r_r.io_hold <= `BYTE_RST;
            r_r.res <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs are plain flop bits, no logic after the register
    assign res = r_r.res;
    assign flags = r_r.flags;
    assign busy = r_r.state[1]; // st_io2 one-hot bit
endmodule : bit_shift_flag_unit

/* File: bench/bit_shift_flag_unit_props.sv */
`timescale 1ns/1ps
module bit_shift_flag_unit_props
    import bit_shift_flag_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input req_t req,
    input wire logic [7:0] io_rdata,
    input res_t res,
    input wire logic [7:0] flags,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a request accepted while idle
    sequence take(op_t o);
        req.valid && !busy && req.op == o;
    endsequence
    sequence take_shift;
        req.valid && !busy && req.op inside {shift_left_logical, shift_right_logical,
            rotate_left_carry, rotate_right_carry, shift_right_arith};
    endsequence
    // second cycle of an i/o op, then the write
    sequence io_done;
        ##1 busy ##1 (res.io_we && res.done && res.cycles == 2'h2 && flags == $past(flags, 2));
    endsequence
    a_io_set_bit: assert property (take(io_bit_set) |-> io_done and ##2
        (res.io_data == ($past(io_rdata, 2) | (8'h01 << $past(req.sel, 2)))))
        else $error("i/o bit set wrong");
    a_io_clear_bit: assert property (take(io_bit_clear) |-> io_done and ##2
        (res.io_data == ($past(io_rdata, 2) & ~(8'h01 << $past(req.sel, 2)))))
        else $error("i/o bit clear wrong");
    a_busy_one_cycle: assert property (busy |=> !busy && !res.reg_we && res.io_we)
        else $error("busy phase wrong");
    a_shl_result: assert property (take(shift_left_logical) |=> res.reg_we &&
        res.reg_data == {$past(req.operand[6:0]), 1'b0} && flags[0] == $past(req.operand[7]))
        else $error("left shift wrong");
    a_shift_flags: assert property (take_shift |=> flags[1] == (res.reg_data == 8'h00) &&
        flags[2] == res.reg_data[7] && flags[3] == (flags[2] ^ flags[0]))
        else $error("shift flags wrong");
    a_rol_carry: assert property (take(rotate_left_carry) |=>
        res.reg_data == {$past(req.operand[6:0]), $past(flags[0])})
        else $error("rotate left wrong");
    a_swap_nibbles: assert property (take(nibble_swap) |=> res.reg_we &&
        flags == $past(flags) &&
        res.reg_data == {$past(req.operand[3:0]), $past(req.operand[7:4])})
        else $error("nibble swap wrong");
    a_index_set: assert property (take(flag_index_set) |=>
        flags == ($past(flags) | (8'h01 << $past(req.sel))))
        else $error("flag index set wrong");
endmodule : bit_shift_flag_unit_props

bind bit_shift_flag_unit bit_shift_flag_unit_props u_props (.clk(clk), .rst_n(rst_n),
    .req(req), .io_rdata(io_rdata), .res(res), .flags(flags), .busy(busy));

/* File: bench/tb_bit_shift_flag_unit.sv */
`timescale 1ns/1ps
module tb_bit_shift_flag_unit;
    import bit_shift_flag_pkg::*;
    logic clk;
    logic rst_n;
    req_t req;
    logic [7:0] io_rdata;
    res_t res;
    logic [7:0] flags;
    logic busy;
    logic [7:0] f;
    logic [8:0] r;
    int n_errors;
    int n_checks;
    op_t set_ops[8] = '{carry_set, zero_set, negative_set, overflow_flag_set,
        signed_flag_set, half_carry_set, transfer_set, int_enable_set};
    op_t clr_ops[8] = '{carry_clear, zero_clear, negative_clear, overflow_flag_clear,
        signed_flag_clear, half_carry_clear, transfer_clear, int_enable_clear};
    op_t sh_ops[6] = '{shift_left_logical, shift_right_logical, rotate_left_carry,
        rotate_right_carry, shift_right_arith, nibble_swap};
    logic [7:0] vals[4] = '{8'h80, 8'h01, 8'h00, 8'hc3};

    bit_shift_flag_unit dut (.clk(clk), .rst_n(rst_n), .req(req), .io_rdata(io_rdata),
        .res(res), .flags(flags), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // compare two bytes and count
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one request; valid drops during the busy cycle so the i/o op is not retaken
    task run(input op_t op, input logic [2:0] sel, input logic [7:0] a, input logic [7:0] io);
        logic two;
        logic wr;
        two = (op == io_bit_set) || (op == io_bit_clear);
        wr = op inside {shift_left_logical, shift_right_logical, rotate_left_carry,
            rotate_right_carry, shift_right_arith, nibble_swap, transfer_flag_to_bit};
        req = '{1'b1, op, sel, a};
        io_rdata = io;
        @(posedge clk);
        #1;
        if (two) begin
            req.valid = 1'b0;
            chk({7'h00, busy}, 8'h01);
            @(posedge clk);
            #1;
        end
        chk({7'h00, busy}, 8'h00);
        chk({7'h00, res.done}, 8'h01);
        chk({6'h00, res.cycles}, two ? 8'h02 : 8'h01);
        chk({6'h00, res.io_we, res.reg_we}, {6'h00, two, wr});
    endtask : run
    // expected {carry, result} of a shift, rotate or swap
    function automatic logic [8:0] shf(op_t op, logic [7:0] a, logic c);
        case (op)
            shift_left_logical: return {a, 1'b0};
            shift_right_logical: return {a[0], 1'b0, a[7:1]};
            rotate_left_carry: return {a, c};
            rotate_right_carry: return {a[0], c, a[7:1]};
            shift_right_arith: return {a[0], a[7], a[7:1]};
            default: return {c, a[3:0], a[7:4]};
        endcase
    endfunction : shf
    task final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // watchdog, far beyond the 178 cycles the tests need
    initial begin
        #10000;
        n_errors++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        req = '0;
        io_rdata = 8'h00;
        f = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(flags, 8'h00);
        for (int i = 0; i < 8; i++) begin
            run(io_bit_set, i[2:0], 8'h00, 8'h00);
            chk(res.io_data, 8'h01 << i);
            run(io_bit_clear, i[2:0], 8'h00, 8'h5a);
            chk(res.io_data, 8'h5a & ~(8'h01 << i));
            chk(flags, f);
        end
        // all flags through every set and clear path, back to back
        for (int i = 0; i < 8; i++) begin
            run(flag_index_set, i[2:0], 8'h00, 8'h00);
            f[i] = 1'b1;
            chk(flags, f);
        end
        for (int i = 0; i < 8; i++) begin
            run(clr_ops[i], 3'h0, 8'h00, 8'h00);
            f[i] = 1'b0;
            chk(flags, f);
        end
        for (int i = 0; i < 8; i++) begin
            run(set_ops[i], 3'h0, 8'h00, 8'h00);
            f[i] = 1'b1;
            chk(flags, f);
            run(flag_index_clear, i[2:0], 8'h00, 8'h00);
            f[i] = 1'b0;
            chk(flags, f);
        end
        // shifts with both carry inputs
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 8; j++) begin
                run(j[0] ? carry_set : carry_clear, 3'h0, 8'h00, 8'h00);
                f[0] = j[0];
                r = shf(sh_ops[k], vals[j[2:1]], f[0]);
                run(sh_ops[k], 3'h0, vals[j[2:1]], 8'h00);
                chk(res.reg_data, r[7:0]);
                if (k < 5) begin
                    f[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
                end
                chk(flags, f);
            end
        end
        // transfer flag to and from each bit
        for (int i = 0; i < 8; i++) begin
            run(bit_to_transfer_flag, i[2:0], 8'ha5, 8'h00);
            f[6] = 1'(8'ha5 >> i);
            chk(flags, f);
            run(transfer_flag_to_bit, i[2:0], 8'h0f, 8'h00);
            chk(res.reg_data, f[6] ? (8'h0f | (8'h01 << i)) : (8'h0f & ~(8'h01 << i)));
            chk(flags, f);
        end
        req.valid = 1'b0;
        final_report();
    end
endmodule : tb_bit_shift_flag_unit
